// >>> design/emu_stimulus_select_defines.svh
// Offsets, field positions, codes and reset values of the stimulus-two bank
// Included by the design modules and the bench
`ifndef EMU_STIMULUS_SELECT_DEFINES_SVH
`define EMU_STIMULUS_SELECT_DEFINES_SVH
`define IDX_RESPONSE 8'h36
`define IDX_THRESHOLD 8'h37
`define IDX_RATIO 8'h38
`define RST_RESPONSE 8'h09
`define RST_THRESHOLD 8'h00
`define RST_RATIO 8'h04
`define MAG_MSB 7
`define MAG_LSB 4
`define PUPD_MSB 5
`define PUPD_LSB 4
`define SEL_REMOVE 4'h0
`define SEL_VOLT_POS 4'h1
`define SEL_VOLT_NEG 4'h2
`define SEL_VOLT_BOTH 4'h3
`define SEL_RES_POS 4'h4
`define SEL_RSVD_A 4'h5
`define SEL_DIV_POS 4'h6
`define SEL_RES_NEG 4'h7
`define SEL_RSVD_B 4'h8
`define SEL_DIV_NEG 4'h9
`define SEL_SHORT 4'hA
`define SEL_RSVD_C 4'hB
`define SEL_DIV_BOTH 4'hC
`define SEL_RES_BOTH 4'hD
`define SEL_PD_CTRL_A 4'hE
`define SEL_PD_CTRL_B 4'hF
`define MAG_PULLDOWN 4'h0
`define MAG_RSVD 4'hF
`define TH_RSVD 4'hF
`define RATIO_RSVD 3'h7
`define STIM_VBUS_READY 3'h0
`define STIM_VBUS_PRESENT 3'h7
`endif

// >>> design/emu_stimulus_select_pkg.sv
// Types shared by the stimulus-two configuration bank
// Assumes the defines header is on the include path
`default_nettype none
package emu_stimulus_select_pkg;
  typedef enum logic [4:0] {
    KIND_NONE = 5'h01,
    KIND_VOLT = 5'h02,
    KIND_RES = 5'h04,
    KIND_DIV = 5'h08,
    KIND_SHORT = 5'h10
  } line_kind_t;
  typedef struct packed {
    logic [3:0] magnitude;
    logic [3:0] select;
  } response_t;
  typedef struct packed {
    response_t response;
    logic [1:0] pulldown_current;
    logic [3:0] threshold;
    logic [2:0] ratio;
  } profile_load_t;
  typedef struct packed {
    line_kind_t kind;
    logic [3:0] magnitude;
    logic reset_pulldown;
  } line_drive_t;
endpackage : emu_stimulus_select_pkg
`default_nettype wire

// >>> design/stimulus_select_field_guard.sv
// Next values of the three registers for a profile load
// Assumes a combinational caller that registers the result
`default_nettype none
`include "emu_stimulus_select_defines.svh"
module stimulus_select_field_guard
  import emu_stimulus_select_pkg::*;
(
  input wire profile_load_t cur_i,
  input wire profile_load_t new_i,
  input wire logic legacy_i,
  output profile_load_t next_o
);
  always_comb begin
    next_o = cur_i;
    if (!(new_i.response.select inside {`SEL_RSVD_A, `SEL_RSVD_B, `SEL_RSVD_C})) begin
      next_o.response.select = new_i.response.select;
    end
    if (new_i.response.magnitude != `MAG_RSVD) begin
      next_o.response.magnitude = new_i.response.magnitude;
    end
    if (!legacy_i) begin
      next_o.pulldown_current = new_i.pulldown_current;
      if (new_i.threshold != `TH_RSVD) begin
        next_o.threshold = new_i.threshold;
      end
    end
    if (legacy_i && new_i.ratio != `RATIO_RSVD) begin
      next_o.ratio = new_i.ratio;
    end
  end
endmodule : stimulus_select_field_guard
`default_nettype wire

// >>> design/stimulus_select_line_engine.sv
// Drive state of the positive (0) and negative (1) data output lines
// Assumes one-cycle apply and emulation-reset pulses on clk_i
`default_nettype none
`include "emu_stimulus_select_defines.svh"
module stimulus_select_line_engine
  import emu_stimulus_select_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic apply_i,
  input wire logic emulation_reset_i,
  input wire response_t response_i,
  input wire logic [2:0] stimulus_select_i,
  output line_drive_t positive_line_out_o,
  output line_drive_t negative_line_out_o
);
  line_drive_t line_q [2];
  for (genvar l = 0; l < 2; l++) begin : g_line
    localparam logic [3:0] VOLT_ONE = (l == 0) ? `SEL_VOLT_POS : `SEL_VOLT_NEG;
    localparam logic [3:0] RES_ONE = (l == 0) ? `SEL_RES_POS : `SEL_RES_NEG;
    localparam logic [3:0] DIV_ONE = (l == 0) ? `SEL_DIV_POS : `SEL_DIV_NEG;
    line_kind_t hit;
    logic single;
    always_comb begin
      hit = KIND_NONE;
      single = response_i.select inside {VOLT_ONE, RES_ONE, DIV_ONE};
      case (response_i.select)
        VOLT_ONE, `SEL_VOLT_BOTH: hit = KIND_VOLT;
        RES_ONE, `SEL_RES_BOTH: hit = KIND_RES;
        DIV_ONE, `SEL_DIV_BOTH: hit = KIND_DIV;
        `SEL_SHORT: hit = KIND_SHORT;
        default: hit = KIND_NONE;
      endcase
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        line_q[l] <= '{kind: KIND_NONE, magnitude: 4'h0, reset_pulldown: 1'b0};
      end else if (emulation_reset_i) begin
        line_q[l].kind <= KIND_NONE;
        line_q[l].reset_pulldown <= 1'b1;
      end else if (apply_i) begin
        case (response_i.select)
          `SEL_REMOVE: line_q[l].kind <= KIND_NONE;
          `SEL_PD_CTRL_A, `SEL_PD_CTRL_B: begin
            if (stimulus_select_i == `STIM_VBUS_PRESENT) begin
              line_q[l].reset_pulldown <= 1'b0;
            end
          end
          default: begin
            if (hit != KIND_NONE) begin
              line_q[l].kind <= hit;
              line_q[l].magnitude <= response_i.magnitude;
              if (single && !(stimulus_select_i == `STIM_VBUS_READY && line_q[l].kind == KIND_NONE)) begin
                line_q[l].reset_pulldown <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end
  assign positive_line_out_o = line_q[0];
  assign negative_line_out_o = line_q[1];
endmodule : stimulus_select_line_engine
`default_nettype wire

// >>> design/emulation_stimulus_two_config.sv
// Stimulus-two configuration bank of a preloaded charger emulation profile
// Assumes a classic Wishbone master on clk_i and profile loads from the same domain
`default_nettype none
`include "emu_stimulus_select_defines.svh"
module emulation_stimulus_two_config
  import emu_stimulus_select_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic profile_load_i,
  input wire profile_load_t profile_data_i,
  input wire logic legacy_profile_i,
  input wire logic [2:0] stimulus_select_i,
  input wire logic emulation_reset_i,
  input wire logic response_apply_i,
  output line_drive_t positive_line_out_o,
  output line_drive_t negative_line_out_o,
  output logic [1:0] pulldown_current_o,
  output logic pulldown_current_valid_o,
  output logic [3:0] detect_threshold_o,
  output logic detect_threshold_valid_o,
  output logic [2:0] divider_ratio_o,
  output logic divider_ratio_valid_o
);

  // Register state
  response_t response_q;
  logic [1:0] pulldown_current_q;
  logic [3:0] detect_threshold_q;
  logic [2:0] divider_ratio_q;
  profile_load_t cur;
  profile_load_t next;
  logic ack_q;
  logic [31:0] dat_q;
  logic [7:0] rd_idx_q;
  logic [7:0] idx;
  logic req;
  logic sel_volt;
  logic sel_div;
  logic stim_vbus;

  assign cur = '{response: response_q, pulldown_current: pulldown_current_q,
                 threshold: detect_threshold_q, ratio: divider_ratio_q};

  // Refusal of reserved codes and profile-type gating
  stimulus_select_field_guard u_guard (
    .cur_i(cur),
    .new_i(profile_data_i),
    .legacy_i(legacy_profile_i),
    .next_o(next)
  );

  // Whole bank loads in one edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      response_q <= response_t'(`RST_RESPONSE);
      pulldown_current_q <= 2'(`RST_THRESHOLD >> `PUPD_LSB);
      detect_threshold_q <= 4'(`RST_THRESHOLD);
      divider_ratio_q <= 3'(`RST_RATIO);
    end else if (profile_load_i) begin
      response_q <= next.response;
      pulldown_current_q <= next.pulldown_current;
      detect_threshold_q <= next.threshold;
      divider_ratio_q <= next.ratio;
    end
  end

  // Line drive state
  stimulus_select_line_engine u_lines (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .apply_i(response_apply_i),
    .emulation_reset_i(emulation_reset_i),
    .response_i(response_q),
    .stimulus_select_i(stimulus_select_i),
    .positive_line_out_o(positive_line_out_o),
    .negative_line_out_o(negative_line_out_o)
  );

  // Which settings are live for the analog side
  assign sel_volt = response_q.select inside {`SEL_VOLT_POS, `SEL_VOLT_NEG, `SEL_VOLT_BOTH};
  assign sel_div = response_q.select inside {`SEL_DIV_POS, `SEL_DIV_NEG, `SEL_DIV_BOTH};
  assign stim_vbus = stimulus_select_i inside {`STIM_VBUS_READY, `STIM_VBUS_PRESENT};

  assign pulldown_current_o = pulldown_current_q;
  assign pulldown_current_valid_o = sel_volt && response_q.magnitude == `MAG_PULLDOWN
                                    && !legacy_profile_i;
  assign detect_threshold_o = detect_threshold_q;
  assign detect_threshold_valid_o = !stim_vbus && !legacy_profile_i;
  assign divider_ratio_o = divider_ratio_q;
  assign divider_ratio_valid_o = sel_div && legacy_profile_i;

  // Wishbone slave: read-only bank, writes acked and dropped
  assign idx = adr_i[9:2];
  assign req = cyc_i && stb_i && !ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
      rd_idx_q <= 8'h00;
    end else if (req) begin
      rd_idx_q <= idx;
      case (idx)
        `IDX_RESPONSE: dat_q <= {24'h00_0000, response_q};
        `IDX_THRESHOLD: dat_q <= {26'h000_0000, pulldown_current_q, detect_threshold_q};
        `IDX_RATIO: dat_q <= {29'h000_0000, divider_ratio_q};
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic plain_apply;
  assign plain_apply = response_apply_i && !emulation_reset_i;

  chk_resp_layout: assert property (
    req && idx == `IDX_RESPONSE |=> ack_o && dat_o[7:4] == $past(response_q.magnitude)
                                   && dat_o[3:0] == $past(response_q.select))
    else $error("response register layout wrong");

  chk_remove_both: assert property (
    plain_apply && response_q.select == `SEL_REMOVE
    |=> positive_line_out_o.kind == KIND_NONE && negative_line_out_o.kind == KIND_NONE)
    else $error("remove did not clear both lines");

  chk_volt_pos: assert property (
    plain_apply && response_q.select == `SEL_VOLT_POS
    |=> positive_line_out_o.kind == KIND_VOLT && $stable(negative_line_out_o.kind))
    else $error("voltage not on positive line only");

  chk_res_both: assert property (
    plain_apply && response_q.select == `SEL_RES_BOTH
    |=> positive_line_out_o.kind == KIND_RES && negative_line_out_o.kind == KIND_RES)
    else $error("resistor not on both lines");

  chk_short_lines: assert property (
    plain_apply && response_q.select == `SEL_SHORT
    |=> positive_line_out_o.kind == KIND_SHORT && negative_line_out_o.kind == KIND_SHORT)
    else $error("lines not shorted");

  chk_div_neg: assert property (
    plain_apply && response_q.select == `SEL_DIV_NEG
    |=> negative_line_out_o.kind == KIND_DIV
        && negative_line_out_o.magnitude == $past(response_q.magnitude))
    else $error("divider not on negative line");

  chk_pd_drop: assert property (
    plain_apply && response_q.select inside {`SEL_PD_CTRL_A, `SEL_PD_CTRL_B}
    && stimulus_select_i == `STIM_VBUS_PRESENT
    |=> !positive_line_out_o.reset_pulldown && !negative_line_out_o.reset_pulldown)
    else $error("reset pull-downs not dropped");

  chk_pd_keep: assert property (
    plain_apply && response_q.select inside {`SEL_PD_CTRL_A, `SEL_PD_CTRL_B}
    && stimulus_select_i == `STIM_VBUS_READY
    |=> $stable(positive_line_out_o) && $stable(negative_line_out_o))
    else $error("pull-down control changed lines");

  chk_sel_refused: assert property (
    profile_load_i && profile_data_i.response.select inside {`SEL_RSVD_A, `SEL_RSVD_B, `SEL_RSVD_C}
    |=> response_q.select == $past(response_q.select))
    else $error("reserved response code accepted");

  chk_mag_refused: assert property (
    profile_load_i && profile_data_i.response.magnitude == `MAG_RSVD
    |=> response_q.magnitude == $past(response_q.magnitude))
    else $error("reserved magnitude accepted");

  chk_single_pd: assert property (
    plain_apply && response_q.select == `SEL_RES_POS && stimulus_select_i != `STIM_VBUS_READY
    |=> !positive_line_out_o.reset_pulldown && $stable(negative_line_out_o))
    else $error("single-line pull-down handling wrong");

  chk_sink_valid: assert property (
    sel_volt && response_q.magnitude != `MAG_PULLDOWN |-> !pulldown_current_valid_o)
    else $error("sink current live without pull-down magnitude");

  chk_thr_ignored: assert property (
    stimulus_select_i inside {`STIM_VBUS_READY, `STIM_VBUS_PRESENT} |-> !detect_threshold_valid_o)
    else $error("threshold live for bus stimulus");

  chk_thr_frozen: assert property (
    profile_load_i && legacy_profile_i |=> $stable(detect_threshold_q) && $stable(pulldown_current_q))
    else $error("threshold updated under legacy profile");

  chk_ratio_frozen: assert property (
    profile_load_i && !legacy_profile_i |-> !divider_ratio_valid_o ##1 $stable(divider_ratio_q))
    else $error("ratio updated under standard profile");

  chk_atomic_load: assert property (
    profile_load_i && legacy_profile_i && profile_data_i.ratio != `RATIO_RSVD
    && !(profile_data_i.response.select inside {`SEL_RSVD_A, `SEL_RSVD_B, `SEL_RSVD_C})
    |=> divider_ratio_q == $past(profile_data_i.ratio)
        && response_q.select == $past(profile_data_i.response.select))
    else $error("bank not loaded in one cycle");

  chk_upper_zero: assert property (
    ack_o && rd_idx_q == `IDX_RATIO |-> dat_o[31:3] == 29'h000_0000)
    else $error("unimplemented ratio bits not zero");

  chk_bus_ack: assert property (
    req |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after request");

  chk_thr_layout: assert property (
    req && idx == `IDX_THRESHOLD
    |=> dat_o == {26'h000_0000, $past(pulldown_current_q), $past(detect_threshold_q)})
    else $error("threshold layout wrong");

  chk_ratio_layout: assert property (
    req && idx == `IDX_RATIO
    |=> dat_o[2:0] == $past(divider_ratio_q))
    else $error("ratio layout wrong");

  chk_unmapped_zero: assert property (
    req && !(idx inside {`IDX_RESPONSE, `IDX_THRESHOLD, `IDX_RATIO})
    |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  chk_volt_neg: assert property (
    plain_apply && response_q.select == `SEL_VOLT_NEG
    |=> negative_line_out_o.kind == KIND_VOLT && $stable(positive_line_out_o.kind))
    else $error("voltage not on negative line only");

  chk_volt_both: assert property (
    plain_apply && response_q.select == `SEL_VOLT_BOTH
    |=> positive_line_out_o.kind == KIND_VOLT && negative_line_out_o.kind == KIND_VOLT)
    else $error("voltage not on both lines");

  chk_res_pos: assert property (
    plain_apply && response_q.select == `SEL_RES_POS
    |=> positive_line_out_o.kind == KIND_RES && $stable(negative_line_out_o.kind))
    else $error("resistor not on positive line only");

  chk_res_neg: assert property (
    plain_apply && response_q.select == `SEL_RES_NEG
    |=> negative_line_out_o.kind == KIND_RES && $stable(positive_line_out_o.kind))
    else $error("resistor not on negative line only");

  chk_div_both: assert property (
    plain_apply && response_q.select == `SEL_DIV_BOTH
    |=> positive_line_out_o.kind == KIND_DIV && negative_line_out_o.kind == KIND_DIV)
    else $error("divider not on both lines");

  chk_mag_copied: assert property (
    plain_apply && response_q.select inside {`SEL_VOLT_BOTH, `SEL_RES_BOTH, `SEL_DIV_BOTH}
    |=> positive_line_out_o.magnitude == $past(response_q.magnitude)
        && negative_line_out_o.magnitude == $past(response_q.magnitude))
    else $error("magnitude not carried to lines");

  chk_thr_refused: assert property (
    profile_load_i && profile_data_i.threshold == `TH_RSVD |=> $stable(detect_threshold_q))
    else $error("reserved threshold accepted");

  chk_ratio_refused: assert property (
    profile_load_i && profile_data_i.ratio == `RATIO_RSVD |=> $stable(divider_ratio_q))
    else $error("reserved ratio accepted");

  chk_thr_load: assert property (
    profile_load_i && !legacy_profile_i && profile_data_i.threshold != `TH_RSVD
    |=> detect_threshold_q == $past(profile_data_i.threshold)
        && pulldown_current_q == $past(profile_data_i.pulldown_current))
    else $error("threshold register not loaded");

  chk_sel_load: assert property (
    profile_load_i && profile_data_i.response.magnitude != `MAG_RSVD
    && !(profile_data_i.response.select inside {`SEL_RSVD_A, `SEL_RSVD_B, `SEL_RSVD_C})
    |=> response_q == $past(profile_data_i.response))
    else $error("response register not loaded");

  chk_emu_reset: assert property (
    emulation_reset_i
    |=> positive_line_out_o.kind == KIND_NONE && negative_line_out_o.kind == KIND_NONE
        && positive_line_out_o.reset_pulldown && negative_line_out_o.reset_pulldown)
    else $error("emulation reset state wrong");

  chk_pd_other: assert property (
    plain_apply && response_q.select inside {`SEL_PD_CTRL_A, `SEL_PD_CTRL_B}
    && !(stimulus_select_i inside {`STIM_VBUS_READY, `STIM_VBUS_PRESENT})
    |=> $stable(positive_line_out_o) && $stable(negative_line_out_o))
    else $error("pull-down control acted on other stimulus");

  chk_single_keep: assert property (
    plain_apply && response_q.select == `SEL_VOLT_POS && stimulus_select_i == `STIM_VBUS_READY
    && positive_line_out_o.kind == KIND_NONE
    |=> positive_line_out_o.reset_pulldown == $past(positive_line_out_o.reset_pulldown))
    else $error("idle pull-down dropped on bus-ready stimulus");

  chk_remove_pd: assert property (
    plain_apply && response_q.select == `SEL_REMOVE
    |=> positive_line_out_o.reset_pulldown == $past(positive_line_out_o.reset_pulldown)
        && negative_line_out_o.reset_pulldown == $past(negative_line_out_o.reset_pulldown))
    else $error("remove touched reset pull-downs");

  cov_load_std: cover property (profile_load_i && !legacy_profile_i ##1 detect_threshold_valid_o);
  cov_volt_apply: cover property (plain_apply && response_q.select == `SEL_VOLT_BOTH);
  cov_refused: cover property (profile_load_i && profile_data_i.response.select == `SEL_RSVD_B);
  cov_divider: cover property (divider_ratio_valid_o ##1 plain_apply);
  cov_pd_drop: cover property (plain_apply && stimulus_select_i == `STIM_VBUS_PRESENT);

endmodule : emulation_stimulus_two_config
`default_nettype wire

// >>> tb/portable_device_model.sv
// Portable device on the two data output lines: reports what it senses
// Assumes the line drive outputs of the stimulus-two bank, same clock domain
`default_nettype none
module portable_device_model
  import emu_stimulus_select_pkg::*;
(
  input wire line_drive_t positive_line_i,
  input wire line_drive_t negative_line_i,
  output logic lines_shorted_o,
  output logic [1:0] pulldown_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Low resistance between the lines is seen only when both carry it
  assign lines_shorted_o = (positive_line_i.kind == KIND_SHORT) && (negative_line_i.kind == KIND_SHORT);
  assign pulldown_seen_o = {negative_line_i.reset_pulldown, positive_line_i.reset_pulldown};
endmodule : portable_device_model
`default_nettype wire

// >>> tb/emulation_stimulus_two_config_tb.sv
// Self-checking bench for the stimulus-two configuration bank
// Assumes the design package and defines header on the include path
`default_nettype none
`include "emu_stimulus_select_defines.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module emulation_stimulus_two_config_tb
  import emu_stimulus_select_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {profile_load_t d; logic leg; logic [23:0] exp;} row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o;
  logic we_i = 1'b0;
  logic [3:0] sel_i = 4'hF;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic ack_o;
  logic profile_load_i = 1'b0;
  profile_load_t profile_data_i = '0;
  logic legacy_profile_i = 1'b0;
  logic [2:0] stimulus_select_i = 3'h0;
  logic emulation_reset_i = 1'b0;
  logic response_apply_i = 1'b0;
  line_drive_t positive_line_out_o, negative_line_out_o;
  logic [1:0] pulldown_current_o;
  logic [3:0] detect_threshold_o;
  logic [2:0] divider_ratio_o;
  logic pulldown_current_valid_o, detect_threshold_valid_o, divider_ratio_valid_o;
  logic lines_shorted;
  logic [1:0] pulldown_seen;
  int error_cnt = 0;
  int checks = 0;
  row_t rows [5];
  logic [3:0] codes [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9, 4'hA, 4'hC, 4'hD};
  logic [31:0] rdat;
  logic [3:0] s;
  logic ph, nh, ps, ns;

  always #2 clk_i = ~clk_i;

  emulation_stimulus_two_config emulation_stimulus_two_config_inst (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .profile_load_i(profile_load_i), .profile_data_i(profile_data_i),
    .legacy_profile_i(legacy_profile_i), .stimulus_select_i(stimulus_select_i),
    .emulation_reset_i(emulation_reset_i), .response_apply_i(response_apply_i),
    .positive_line_out_o(positive_line_out_o), .negative_line_out_o(negative_line_out_o),
    .pulldown_current_o(pulldown_current_o), .pulldown_current_valid_o(pulldown_current_valid_o),
    .detect_threshold_o(detect_threshold_o), .detect_threshold_valid_o(detect_threshold_valid_o),
    .divider_ratio_o(divider_ratio_o), .divider_ratio_valid_o(divider_ratio_valid_o));

  portable_device_model portable_device_model_inst (.positive_line_i(positive_line_out_o),
    .negative_line_i(negative_line_out_o), .lines_shorted_o(lines_shorted), .pulldown_seen_o(pulldown_seen));

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] idx, input logic wr, output logic [31:0] rd);
    int n = 0;
    @(posedge clk_i);
    adr_i <= {idx, 2'b00};
    we_i <= wr;
    dat_i <= 32'hFFFF_FFFF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      give_verdict();
    end
  endtask : wb

  task automatic load(input profile_load_t d, input logic leg);
    @(posedge clk_i);
    profile_data_i <= d;
    legacy_profile_i <= leg;
    profile_load_i <= 1'b1;
    @(posedge clk_i);
    profile_load_i <= 1'b0;
  endtask : load

  // One pulse of emulation reset or of apply, then outputs settle
  task automatic act(input logic emu, input logic [2:0] stim);
    @(posedge clk_i);
    stimulus_select_i <= stim;
    emulation_reset_i <= emu;
    response_apply_i <= ~emu;
    @(posedge clk_i);
    emulation_reset_i <= 1'b0;
    response_apply_i <= 1'b0;
    #1;
  endtask : act

  function automatic line_kind_t kind_of(input logic [3:0] c);
    case (c)
      4'h1, 4'h2, 4'h3: kind_of = KIND_VOLT;
      4'h4, 4'h7, 4'hD: kind_of = KIND_RES;
      4'h6, 4'h9, 4'hC: kind_of = KIND_DIV;
      4'hA: kind_of = KIND_SHORT;
      default: kind_of = KIND_NONE;
    endcase
  endfunction : kind_of

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    rows[0] = {4'h2, 4'h3, 2'h2, 4'h3, 3'h1, 1'b0, 24'h23_2304};
    rows[1] = {4'h1, 4'h6, 2'h1, 4'h5, 3'h6, 1'b1, 24'h16_2306};
    rows[2] = {4'hF, 4'h5, 2'h3, 4'hF, 3'h2, 1'b0, 24'h16_3306};
    rows[3] = {4'h4, 4'h8, 2'h0, 4'h1, 3'h7, 1'b1, 24'h46_3306};
    rows[4] = {4'hE, 4'hB, 2'h0, 4'h1, 3'h0, 1'b1, 24'hE6_3300};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("pos_reset", 10'h020, positive_line_out_o)
    wb(`IDX_RESPONSE, 1'b0, rdat);
    `CHK("resp_reset", 32'h0000_0009, rdat)
    wb(`IDX_THRESHOLD, 1'b0, rdat);
    `CHK("th_reset", 32'h0000_0000, rdat)
    wb(`IDX_RATIO, 1'b0, rdat);
    `CHK("ratio_reset", 32'h0000_0004, rdat)
    for (int i = 0; i < 5; i++) begin
      load(rows[i].d, rows[i].leg);
      wb(`IDX_RESPONSE, 1'b0, rdat);
      `CHK("resp_row", {24'h0, rows[i].exp[23:16]}, rdat)
      wb(`IDX_THRESHOLD, 1'b0, rdat);
      `CHK("th_row", {24'h0, rows[i].exp[15:8]}, rdat)
      wb(`IDX_RATIO, 1'b0, rdat);
      `CHK("ratio_row", {24'h0, rows[i].exp[7:0]}, rdat)
    end
    `CHK("pupd_out", 2'h3, pulldown_current_o)
    `CHK("th_out", 4'h3, detect_threshold_o)
    `CHK("ratio_out", 3'h0, divider_ratio_o)
    wb(`IDX_RESPONSE, 1'b1, rdat);
    wb(`IDX_RESPONSE, 1'b0, rdat);
    `CHK("resp_ro", 32'h0000_00E6, rdat)
    wb(8'h39, 1'b0, rdat);
    `CHK("unmapped", 32'h0000_0000, rdat)
    // Every line-drive response code (not remove, reserved or pull-down control) on fresh lines, stimulus not bus-ready
    for (int i = 0; i < 10; i++) begin
      s = codes[i];
      ph = s inside {4'h1, 4'h3, 4'h4, 4'h6, 4'hA, 4'hC, 4'hD};
      nh = s inside {4'h2, 4'h3, 4'h7, 4'h9, 4'hA, 4'hC, 4'hD};
      ps = s inside {4'h1, 4'h4, 4'h6};
      ns = s inside {4'h2, 4'h7, 4'h9};
      act(1'b1, 3'h1);
      load({4'h9, s, 2'h0, 4'h0, 3'h0}, 1'b0);
      act(1'b0, 3'h1);
      `CHK("pos_kind", ph ? kind_of(s) : KIND_NONE, positive_line_out_o.kind)
      `CHK("neg_kind", nh ? kind_of(s) : KIND_NONE, negative_line_out_o.kind)
      `CHK("pds", {~ns, ~ps}, pulldown_seen)
      if (ph) `CHK("pos_mag", 4'h9, positive_line_out_o.magnitude)
      if (s == 4'hA) `CHK("short", 1'b1, lines_shorted)
    end
    act(1'b1, 3'h0);
    load({4'h5, 4'h1, 2'h0, 4'h0, 3'h0}, 1'b0);
    act(1'b0, 3'h0);
    `CHK("pos_keep", {KIND_VOLT, 4'h5, 1'b1}, positive_line_out_o)
    load({4'h2, 4'h4, 2'h0, 4'h0, 3'h0}, 1'b0);
    act(1'b0, 3'h0);
    `CHK("pos_drop", {KIND_RES, 4'h2, 1'b0}, positive_line_out_o)
    load({4'h0, 4'h0, 2'h0, 4'h0, 3'h0}, 1'b0);
    act(1'b0, 3'h0);
    `CHK("remove_pos", KIND_NONE, positive_line_out_o.kind)
    `CHK("remove_neg", KIND_NONE, negative_line_out_o.kind)
    `CHK("remove_pd", 2'h2, pulldown_seen)
    act(1'b1, 3'h0);
    load({4'h0, 4'hE, 2'h0, 4'h0, 3'h0}, 1'b0);
    act(1'b0, 3'h0);
    `CHK("pd_keep", 2'h3, pulldown_seen)
    act(1'b0, 3'h3);
    `CHK("pd_other", 2'h3, pulldown_seen)
    act(1'b0, 3'h7);
    `CHK("pd_drop", 2'h0, pulldown_seen)
    act(1'b1, 3'h7);
    load({4'h0, 4'hF, 2'h0, 4'h0, 3'h0}, 1'b0);
    act(1'b0, 3'h7);
    `CHK("pd_drop_f", 2'h0, pulldown_seen)
    `CHK("th_valid_7", 1'b0, detect_threshold_valid_o)
    @(posedge clk_i);
    stimulus_select_i <= 3'h0;
    #1;
    `CHK("th_valid_0", 1'b0, detect_threshold_valid_o)
    @(posedge clk_i);
    stimulus_select_i <= 3'h3;
    #1;
    `CHK("th_valid_3", 1'b1, detect_threshold_valid_o)
    load({4'h0, 4'h1, 2'h1, 4'h2, 3'h3}, 1'b0);
    #1;
    `CHK("sink_valid", 1'b1, pulldown_current_valid_o)
    `CHK("ratio_valid_std", 1'b0, divider_ratio_valid_o)
    load({4'h0, 4'h6, 2'h1, 4'h2, 3'h3}, 1'b1);
    #1;
    `CHK("th_valid_leg", 1'b0, detect_threshold_valid_o)
    `CHK("ratio_valid_leg", 1'b1, divider_ratio_valid_o)
    `CHK("ratio_leg", 3'h3, divider_ratio_o)
    // Reset in mid-run restores the positive line, ratio and response registers
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("pos_rerst", 10'h020, positive_line_out_o)
    `CHK("ratio_rerst", 3'h4, divider_ratio_o)
    wb(`IDX_RESPONSE, 1'b0, rdat);
    `CHK("resp_rerst", 32'h0000_0009, rdat)
    give_verdict();
  end
endmodule : emulation_stimulus_two_config_tb
`default_nettype wire
